/* File: sim/ifgc_pin_model.sv */
// model of the tuner if carrier and the external gate pulses
`timescale 1ns/100ps
module ifgc_pin_model (
  output ifgc_pkg::ifgc_pins_t pins
);
  // ********************
  // pin levels
  // ********************
  int         half_ns = 0;
  logic       carrier = 1'b0;
  logic [1:0] gate    = 2'b00;

  // carrier parked low when off, so no stray edge reaches the counter
  always begin
    if (half_ns > 0) begin
      #(half_ns) carrier = ~carrier;
    end else begin
      #100 carrier = 1'b0;
    end
  end

  // gate pins only ever driven from outside, never used as outputs
  assign pins = {gate, carrier, carrier};

  // gate is measured rise to rise, so the closing rise is included
  task automatic gate_pulse(input int p, input int w_ns);
    gate[p] = 1'b1;
    #(w_ns / 2) gate[p] = 1'b0;
    #(w_ns / 2) gate[p] = 1'b1;
    #(w_ns / 2) gate[p] = 1'b0;
  endtask : gate_pulse
endmodule : ifgc_pin_model

/* File: sim/ifgc_properties.sv */
// checker of the register bus of the if / gate counter
`timescale 1ns/100ps
module ifgc_checker #(
  parameter int TICK_1K_CYC = 10000
) (
  input wire logic                    mclk,
  input wire logic                    srst,
  input wire ifgc_pkg::ifgc_pins_t    pins,
  input wire ifgc_pkg::ifgc_axi_req_t axi_req,
  input wire ifgc_pkg::ifgc_axi_rsp_t axi_rsp
);
  // ********************
  // handshakes
  // ********************
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (srst);
  logic ar_hs;
  logic aw_hs;

  // both write items offered together by our master, so one flag serves
  assign ar_hs = axi_req.arvalid && axi_rsp.arready;
  assign aw_hs = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;

  a_read_answer: assert property (ar_hs |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_read_single: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
    else $error("read answer repeated");
  a_write_answer: assert property (aw_hs |-> ##2 axi_rsp.bvalid)
    else $error("write answer late");
  a_ar_block: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read address taken during answer");
  a_aw_block: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken during answer");
  a_ctrl_reads_zero: assert property (ar_hs && axi_req.araddr == 8'h8c |=>
    axi_rsp.rdata == 32'h0) else $error("control register not read as zero");
  a_gpin_upper_zero: assert property (ar_hs && axi_req.araddr == 8'h80 |=>
    axi_rsp.rdata[31:2] == 30'h0) else $error("gate pin upper bits set");
  a_status_one_bit: assert property (ar_hs && axi_req.araddr == 8'h84 |=>
    axi_rsp.rdata[31:1] == 31'h0) else $error("status upper bits set");
  a_count_sixteen: assert property (ar_hs && axi_req.araddr == 8'h90 |=>
    axi_rsp.rdata[31:16] == 16'h0) else $error("count wider than sixteen bits");
  a_unmapped_read: assert property (ar_hs && axi_req.araddr < 8'h80 |=>
    axi_rsp.rresp == 2'h2 && axi_rsp.rdata == 32'h0) else $error("unmapped read accepted");
endmodule : ifgc_checker

bind ifgc_top ifgc_checker #(.TICK_1K_CYC(TICK_1K_CYC)) i_chk (
  .mclk(mclk), .srst(srst), .pins(pins), .axi_req(axi_req), .axi_rsp(axi_rsp));

/* File: sim/tb.sv */
// self-checking bench of the if / gate counter
`timescale 1ns/100ps
module tb;
  // ********************
  // signals
  // ********************
  localparam int TICK = 20; // shortened 1 kHz tick keeps the run short
  logic                    mclk        = 1'b0;
  logic                    srst        = 1'b1;
  ifgc_pkg::ifgc_axi_req_t req         = '0;
  ifgc_pkg::ifgc_axi_rsp_t rsp;
  ifgc_pkg::ifgc_pins_t    pins;
  int                      n_errors    = 0;
  int                      comparisons = 0;
  logic [31:0]             d;
  logic [1:0]              r;

  // 10 MHz clock
  always #50 mclk = ~mclk;

  ifgc_top #(.TICK_1K_CYC(TICK)) i_dut (
    .mclk(mclk), .srst(srst), .pins(pins), .axi_req(req), .axi_rsp(rsp));
  ifgc_pin_model i_pins (.pins(pins));

  // ********************
  // tasks
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // rises of a carrier of half period h_ns in a gate of 1, 4 or 8 ticks,
  // every second one on the halved fm path
  function automatic int exp_if(input int f, input int t, input int h_ns);
    int g;
    g = (t == 0) ? 1 : ((t == 1) ? 4 : 8);
    exp_if = (g * TICK * 100 / (2 * h_ns)) >> (f == 2);
  endfunction : exp_if

  // reference ticks in a gate of w_ns: 1 kHz tick, 100 kHz, 900 kHz
  function automatic int exp_ext(input int t, input int w_ns);
    if (t == 0) begin
      exp_ext = w_ns / (TICK * 100);
    end else if (t == 1) begin
      exp_ext = w_ns / 10000;
    end else begin
      exp_ext = w_ns * 9 / 10000;
    end
  endfunction : exp_ext

  // opening edge wait keeps two requests from sharing one time step
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= v;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    rs = rsp.bresp;
    req.bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    v = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask : axr

  // count is read only once the gate flag has dropped
  task automatic wait_idle;
    for (int i = 0; i < 100; i++) begin
      axr(8'h84, d, r);
      if (d[0] === 1'b0) return;
    end
    chk(d, 32'h0);
  endtask : wait_idle

  // watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    give_verdict;
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    int          h;
    int          m;
    int          e;
    logic [3:0]  v;
    logic [31:0] c;
    void'($urandom(32'hdd11c26f));
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      axr(8'h80 + 8'(4 * a), d, r);
      chk(d, 32'h0);
    end
    axr(8'h40, d, r);
    chk(32'(r), 32'h2);
    axw(8'h40, 32'h1, r);
    chk(32'(r), 32'h2);
    axw(8'h84, 32'h1, r);
    chk(32'(r), 32'h0);
    // selection registers read back, gate pin keeps two bits
    for (int i = 0; i < 4; i++) begin
      v = 4'($urandom);
      axw(8'h80, {28'h0, v}, r);
      axr(8'h80, d, r);
      chk(d, {30'h0, v[1:0]});
      axw(8'h88, {28'h0, v}, r);
      axr(8'h88, d, r);
      chk(d, {28'h0, v});
    end
    // timed if gates over every pin mode; a rise may land either side of a gate end
    for (int f = 1; f < 4; f++) begin
      for (int t = 0; t < 3; t++) begin
        h = 300 + $urandom % 300;
        i_pins.half_ns = h;
        axw(8'h88, 32'(f * 4 + t), r);
        axw(8'h8c, 32'h1, r);
        axw(8'h8c, 32'h2, r);
        axr(8'h84, d, r);
        chk(d, 32'h1);
        wait_idle;
        axr(8'h90, d, r);
        e = exp_if(f, t, h);
        chk((d == e + 1) ? 32'(e) : d, 32'(e));
      end
    end
    // open gate counts without start, clear keeps it open
    i_pins.half_ns = 400;
    axw(8'h8c, 32'h1, r);
    axw(8'h88, 32'h7, r);
    repeat (200) @(posedge mclk);
    axr(8'h90, d, r);
    chk(32'(d > 20), 32'h1);
    axw(8'h8c, 32'h1, r);
    axr(8'h90, d, r);
    chk(32'(d < 3), 32'h1);
    repeat (100) @(posedge mclk);
    axr(8'h90, d, r);
    chk(32'(d > 5), 32'h1);
    axw(8'h88, 32'h4, r);
    repeat (10) @(posedge mclk);
    axr(8'h90, c, r);
    repeat (100) @(posedge mclk);
    axr(8'h90, d, r);
    chk(d, c);
    // external gate over each reference and both gate pins
    i_pins.half_ns = 0;
    for (int t = 0; t < 3; t++) begin
      m = 1 + $urandom % 2;
      axw(8'h80, 32'(1 + t % 2), r);
      axw(8'h88, 32'(t), r);
      axw(8'h8c, 32'h1, r);
      axw(8'h8c, 32'h2, r);
      axr(8'h84, d, r);
      chk(d, 32'h1);
      i_pins.gate_pulse(t % 2, m * 180000);
      repeat (10) @(posedge mclk);
      axr(8'h84, d, r);
      chk(d, 32'h1);
      axr(8'h90, c, r);
      e = exp_ext(t, m * 180000);
      chk((c == e + 1) ? 32'(e) : c, 32'(e));
      axw(8'h8c, 32'h0, r);
      axr(8'h90, d, r);
      chk(d, c);
    end
    give_verdict;
  end
endmodule : tb

/* File: src/ifgc_defs.svh */
// constants of the if / gate frequency counter: offsets, fields, codes, timing
`ifndef IFGC_DEFS_SVH
`define IFGC_DEFS_SVH

// ************************************************************
// register indices and byte addresses
// ************************************************************
`define IFGC_IDX_GPIN     8'h20
`define IFGC_IDX_STATUS   8'h21
`define IFGC_IDX_MODE     8'h22
`define IFGC_IDX_CONTROL  8'h23
`define IFGC_IDX_COUNT    8'h24
`define IFGC_ADDR_W       8
`define IFGC_BYTE_SHIFT   2

// ************************************************************
// field positions and codes
// ************************************************************
`define IFGC_CLR_BIT      0
`define IFGC_START_BIT    1
`define IFGC_FUNC_EXT     2'h0
`define IFGC_FUNC_AM      2'h1
`define IFGC_FUNC_FMHALF  2'h2
`define IFGC_FUNC_FM      2'h3
`define IFGC_TB_1MS       2'h0
`define IFGC_TB_4MS       2'h1
`define IFGC_TB_8MS       2'h2
`define IFGC_TB_OPEN      2'h3
`define IFGC_GP_NONE      2'h0
`define IFGC_GP_PIN0      2'h1
`define IFGC_GP_PIN1      2'h2
`define IFGC_GATE_1MS     4'h1
`define IFGC_GATE_4MS     4'h4
`define IFGC_GATE_8MS     4'h8
`define IFGC_COUNT_MAX    16'hffff
`define IFGC_RESP_OKAY    2'h0
`define IFGC_RESP_SLVERR  2'h2

// ************************************************************
// timing
// ************************************************************
`define IFGC_CLK_NS       100
`define IFGC_T1K_NS       1000000
`define IFGC_FCLK_KHZ     14'h2710
`define IFGC_REF100_KHZ   14'h0064
`define IFGC_REF900_KHZ   14'h0384

`endif

/* File: src/ifgc_pkg.sv */
// types of the if / gate frequency counter
`include "ifgc_defs.svh"

package ifgc_pkg;

  // gate sequencer states
  typedef enum logic [2:0] {
    IFGC_IDLE,
    IFGC_WAIT_TICK,
    IFGC_TIMED,
    IFGC_OPEN,
    IFGC_EXT_WAIT,
    IFGC_EXT_OPEN
  } ifgc_state_t;

  // axi4-lite request from master
  typedef struct packed {
    logic                    awvalid;
    logic [`IFGC_ADDR_W-1:0] awaddr;
    logic                    wvalid;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bready;
    logic                    arvalid;
    logic [`IFGC_ADDR_W-1:0] araddr;
    logic                    rready;
  } ifgc_axi_req_t;

  // axi4-lite answer from slave
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ifgc_axi_rsp_t;

  // external pins: fm, am, gate 0, gate 1
  typedef struct packed {
    logic ext_gate_input_1;
    logic ext_gate_input_0;
    logic am_if_input;
    logic fm_if_input;
  } ifgc_pins_t;

  // whole state of the counter block
  typedef struct packed {
    ifgc_state_t             st;
    logic [3:0]              mode;
    logic [1:0]              gpin;
    logic                    gate_open_flag;
    logic [15:0]             count;
    logic [3:0]              s1;
    logic [3:0]              s2;
    logic [3:0]              s3;
    logic                    fm_half;
    logic [13:0]             d1k;
    logic [13:0]             acc;
    logic [3:0]              ms;
    logic                    aw_full;
    logic [`IFGC_ADDR_W-1:0] awaddr;
    logic                    w_full;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } ifgc_regs_t;

endpackage : ifgc_pkg

/* File: src/ifgc_top.sv */
// if / external gate frequency counter with axi4-lite register slave
//
// Functional notes
// R01: timebase sets gate 1/4/8 ms/open or reference
// R02: function selects external gate, am, fm halved, fm
// R03: gate pin select; code 11 prohibited, upper zero
// R04: sixteen bit up-counter counts the routed input
// R05: counter saturates at all ones until cleared
// R06: control bit 0 write one clears counter
// R07: control bit 1 write one starts measurement
// R08: timed gate opens on next 1 kHz tick
// R09: status flag set by start, cleared at close
// R10: open timebase opens gate without any start
// R11: software never starts while open gate selected
// R12: clear works during open gate, gate unchanged
// R13: timed code ends open gate; deselect stops counting
// R14: external gate opens rise, closes next rise
// R15: status flag never reports external gate closure
// R16: software reads count only after flag clears
// R17: count value register returns sixteen bit count
// R18: external count equals width times reference
// R19: gate and references divided from system clock
// R20: software sets gate pin as input
// R21: pins synchronised, each rising edge counted once
// R22: all selection bits reset to zero
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "ifgc_defs.svh"

module ifgc_top #(
  parameter int TICK_1K_CYC = `IFGC_T1K_NS / `IFGC_CLK_NS
) (
  input  wire logic                   mclk,
  input  wire logic                   srst,
  input  wire ifgc_pkg::ifgc_pins_t   pins,
  input  wire ifgc_pkg::ifgc_axi_req_t axi_req,
  output ifgc_pkg::ifgc_axi_rsp_t      axi_rsp
);

  // ************************************************************
  // helpers
  // ************************************************************

  // saturating increment, held at all ones
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == `IFGC_COUNT_MAX) ? v : v + 16'h0001; // R05
  endfunction : sat_inc

  // byte address of a register index
  function automatic logic [`IFGC_ADDR_W-1:0] reg_addr(
    input logic [`IFGC_ADDR_W-1:0] idx);
    reg_addr = `IFGC_ADDR_W'(idx << `IFGC_BYTE_SHIFT);
  endfunction : reg_addr

  // timed gate length in 1 kHz ticks
  function automatic logic [3:0] gate_len(input logic [1:0] tb);
    unique case (tb)
      `IFGC_TB_1MS: gate_len = `IFGC_GATE_1MS; // R01
      `IFGC_TB_4MS: gate_len = `IFGC_GATE_4MS; // R01
      `IFGC_TB_8MS: gate_len = `IFGC_GATE_8MS; // R01
      `IFGC_TB_OPEN: gate_len = `IFGC_GATE_8MS;
    endcase
  endfunction : gate_len

  // ************************************************************
  // state
  // ************************************************************
  ifgc_pkg::ifgc_regs_t r_reg;
  ifgc_pkg::ifgc_regs_t r_next;

  // decoded mode fields and pin events
  logic [1:0]  func;
  logic [1:0]  tb;
  logic        if_mode;
  logic        if_leave;
  logic [3:0]  rise;
  logic        fm_ev;
  logic        if_ev;
  logic        gate_rise;

  // timebase and reference ticks
  logic        tick1k;
  logic [13:0] step;
  logic [14:0] acc_sum;
  logic        ref_tick;

  // bus handshakes and register decode
  logic        awready;
  logic        wready;
  logic        arready;
  logic        do_write;
  logic        wr_gpin;
  logic        wr_mode;
  logic        wr_ctrl;
  logic        wr_ro;
  logic        rd_gpin;
  logic        rd_status;
  logic        rd_mode;
  logic        rd_ctrl;
  logic        rd_count;

  // strobes of the current write and the counter event
  logic        clr;
  logic        start;
  logic        count_ev;

  assign func    = r_reg.mode[3:2];
  assign tb      = r_reg.mode[1:0];
  assign if_mode = (func != `IFGC_FUNC_EXT);

  // handshake outputs come straight from state, data from flops
  assign awready = !r_reg.aw_full && !r_reg.bvalid;
  assign wready  = !r_reg.w_full && !r_reg.bvalid;
  assign arready = !r_reg.rvalid;
  assign do_write = r_reg.aw_full && r_reg.w_full && !r_reg.bvalid;

  assign axi_rsp.awready = awready;
  assign axi_rsp.wready  = wready;
  assign axi_rsp.bvalid  = r_reg.bvalid;
  assign axi_rsp.bresp   = r_reg.bresp;
  assign axi_rsp.arready = arready;
  assign axi_rsp.rvalid  = r_reg.rvalid;
  assign axi_rsp.rdata   = r_reg.rdata;
  assign axi_rsp.rresp   = r_reg.rresp;

  // ************************************************************
  // address decode
  // ************************************************************

  // register map, byte addresses:
  // 0x80 gate pin select, two bits read and written
  // 0x84 gate open status, one bit, read only
  // 0x88 function and timebase select, four bits
  // 0x8c count control, strobes only, reads as zero
  // 0x90 count value, sixteen bits, read only
  // write side looks at the held address, read side at the live one
  always_comb begin
    wr_gpin   = (r_reg.awaddr == reg_addr(`IFGC_IDX_GPIN)); // R03
    wr_mode   = (r_reg.awaddr == reg_addr(`IFGC_IDX_MODE)); // R01 R02
    wr_ctrl   = (r_reg.awaddr == reg_addr(`IFGC_IDX_CONTROL)); // R06 R07
    // writes to read-only registers are answered okay and dropped
    wr_ro     = (r_reg.awaddr == reg_addr(`IFGC_IDX_STATUS)) ||
                (r_reg.awaddr == reg_addr(`IFGC_IDX_COUNT));
    rd_gpin   = (axi_req.araddr == reg_addr(`IFGC_IDX_GPIN)); // R03
    rd_status = (axi_req.araddr == reg_addr(`IFGC_IDX_STATUS)); // R09
    rd_mode   = (axi_req.araddr == reg_addr(`IFGC_IDX_MODE));
    // control is write-only and reads back as zero
    rd_ctrl   = (axi_req.araddr == reg_addr(`IFGC_IDX_CONTROL)); // R07
    rd_count  = (axi_req.araddr == reg_addr(`IFGC_IDX_COUNT)); // R17
  end

  // an if measurement is abandoned when function moves to external or timebase moves to open
  assign if_leave = !if_mode || (tb == `IFGC_TB_OPEN);

  // ************************************************************
  // edges and timebases
  // ************************************************************

  // edges are taken between the second and third stage only
  always_comb begin
    rise = r_reg.s2 & ~r_reg.s3; // R21
    // the halved fm path counts every second rising edge
    fm_ev = rise[0] && r_reg.fm_half; // R02
    unique case (func)
      `IFGC_FUNC_AM:     if_ev = rise[1]; // R02
      `IFGC_FUNC_FMHALF: if_ev = fm_ev; // R02
      `IFGC_FUNC_FM:     if_ev = rise[0]; // R02
      default:           if_ev = 1'b0;
    endcase
    // gate pin code 11 acts as no pin, so a bad write never opens the gate
    unique case (r_reg.gpin)
      `IFGC_GP_PIN0: gate_rise = rise[2]; // R03
      `IFGC_GP_PIN1: gate_rise = rise[3]; // R03
      default:       gate_rise = 1'b0; // R03
    endcase
  end

  // references from the one system clock: 1 kHz by count, others by accumulator
  always_comb begin
    tick1k = (r_reg.d1k == 14'(TICK_1K_CYC - 1)); // R19
    unique case (tb)
      `IFGC_TB_4MS: step = `IFGC_REF100_KHZ; // R01
      `IFGC_TB_8MS: step = `IFGC_REF900_KHZ; // R01
      default:      step = 14'h0000;
    endcase
    // accumulator steps by the reference in kHz and wraps at the clock rate
    acc_sum = {1'b0, r_reg.acc} + {1'b0, step};
    // prohibited reference code 11 gives no ticks at all
    unique case (tb)
      `IFGC_TB_1MS: ref_tick = tick1k; // R19
      `IFGC_TB_OPEN: ref_tick = 1'b0; // R01
      default:      ref_tick = (acc_sum >= {1'b0, `IFGC_FCLK_KHZ}); // R19
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    r_next = r_reg;
    clr    = 1'b0;
    start  = 1'b0;

    // two-stage synchronisers plus edge stage
    r_next.s1 = pins; // R21
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    if (rise[0]) begin
      r_next.fm_half = ~r_reg.fm_half;
    end

    // dividers run free so that the gate waits for a true tick
    r_next.d1k = tick1k ? 14'h0000 : r_reg.d1k + 14'h0001;
    r_next.acc = ref_tick && (tb != `IFGC_TB_1MS)
               ? 14'(acc_sum - {1'b0, `IFGC_FCLK_KHZ})
               : acc_sum[13:0];

    // write address and data may come in either order
    if (axi_req.awvalid && awready) begin
      r_next.aw_full = 1'b1;
      r_next.awaddr  = axi_req.awaddr;
    end
    if (axi_req.wvalid && wready) begin
      r_next.w_full = 1'b1;
      r_next.wdata  = axi_req.wdata;
      r_next.wstrb  = axi_req.wstrb;
    end
    // response leaves once the master has taken it
    if (r_reg.bvalid && axi_req.bready) begin
      r_next.bvalid = 1'b0;
    end
    // both halves held: act on the register and answer
    if (do_write) begin
      r_next.aw_full = 1'b0;
      r_next.w_full  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = `IFGC_RESP_OKAY;
      // only lane 0 carries bits; writes without it are accepted and dropped
      if (wr_mode) begin
        if (r_reg.wstrb[0]) begin
          r_next.mode = r_reg.wdata[3:0]; // R01 R02
        end
      end else if (wr_gpin) begin
        if (r_reg.wstrb[0]) begin
          r_next.gpin = r_reg.wdata[1:0]; // R03
        end
      end else if (wr_ctrl) begin
        // strobes act this cycle and are never stored
        clr   = r_reg.wstrb[0] && r_reg.wdata[`IFGC_CLR_BIT]; // R06
        start = r_reg.wstrb[0] && r_reg.wdata[`IFGC_START_BIT]; // R07
      end else if (!wr_ro) begin
        r_next.bresp = `IFGC_RESP_SLVERR;
      end
    end

    // reads: control reads zero, upper bits zero, unmapped gives slverr
    if (r_reg.rvalid && axi_req.rready) begin
      r_next.rvalid = 1'b0;
    end
    // one read at a time, answered in the next cycle
    if (axi_req.arvalid && arready) begin
      r_next.rvalid = 1'b1;
      r_next.rdata  = 32'h0000_0000;
      r_next.rresp  = `IFGC_RESP_OKAY;
      if (rd_mode) begin
        r_next.rdata[3:0] = r_reg.mode;
      end else if (rd_gpin) begin
        r_next.rdata[1:0] = r_reg.gpin; // R03
      end else if (rd_status) begin
        r_next.rdata[0] = r_reg.gate_open_flag; // R09
      end else if (rd_count) begin
        r_next.rdata[15:0] = r_reg.count; // R17
      end else if (!rd_ctrl) begin
        r_next.rresp = `IFGC_RESP_SLVERR;
      end
    end

    // gate sequencer; count_ev is the edge that may reach the counter
    count_ev = 1'b0;
    unique case (r_reg.st)
      // idle: in an if function the open timebase wins over any start
      ifgc_pkg::IFGC_IDLE: begin
        if (if_mode && tb == `IFGC_TB_OPEN) begin
          r_next.st = ifgc_pkg::IFGC_OPEN; // R10
        end else if (start && if_mode) begin
          r_next.st = ifgc_pkg::IFGC_WAIT_TICK; // R07
          r_next.gate_open_flag = 1'b1; // R09
        end else if (start) begin
          r_next.st = ifgc_pkg::IFGC_EXT_WAIT; // R07
          r_next.gate_open_flag = 1'b1; // R15
        end else if (if_mode) begin
          r_next.gate_open_flag = 1'b0;
        end
      end
      // wait for a true tick so that the window is whole ticks long
      ifgc_pkg::IFGC_WAIT_TICK: begin
        if (if_leave) begin
          r_next.st = ifgc_pkg::IFGC_IDLE;
          r_next.gate_open_flag = 1'b0;
        end else if (tick1k) begin
          r_next.st = ifgc_pkg::IFGC_TIMED; // R08
          r_next.ms = 4'h0;
        end
      end
      // timed window counts pin edges for 1, 4 or 8 ticks
      ifgc_pkg::IFGC_TIMED: begin
        count_ev = if_ev; // R08
        if (if_leave) begin
          r_next.st = ifgc_pkg::IFGC_IDLE;
          r_next.gate_open_flag = 1'b0;
        end else if (tick1k) begin
          r_next.ms = r_reg.ms + 4'h1;
          if (r_reg.ms + 4'h1 == gate_len(tb)) begin
            r_next.st = ifgc_pkg::IFGC_IDLE; // R08
            r_next.gate_open_flag = 1'b0; // R09
          end
        end
      end
      // open window, left only by a timebase or function change
      ifgc_pkg::IFGC_OPEN: begin
        // a deselected pin simply brings no edges; start is ignored here
        count_ev = if_ev; // R13 R11
        if (!if_mode || tb != `IFGC_TB_OPEN) begin
          r_next.st = ifgc_pkg::IFGC_IDLE; // R13
        end
      end
      // external: the first gate pin rise opens
      ifgc_pkg::IFGC_EXT_WAIT: begin
        if (if_mode) begin
          r_next.st = ifgc_pkg::IFGC_IDLE;
          r_next.gate_open_flag = 1'b0;
        end else if (gate_rise) begin
          r_next.st = ifgc_pkg::IFGC_EXT_OPEN; // R14
        end
      end
      // external: reference counted up to the next rise
      ifgc_pkg::IFGC_EXT_OPEN: begin
        count_ev = ref_tick; // R14 R18
        if (if_mode) begin
          r_next.st = ifgc_pkg::IFGC_IDLE;
          r_next.gate_open_flag = 1'b0;
        end else if (gate_rise) begin
          // flag stays up: closure is not shown in status
          r_next.st = ifgc_pkg::IFGC_IDLE; // R14 R15
        end
      end
    endcase

    // external mode: clear strobe is the only thing that drops the flag
    if (clr && !if_mode && r_reg.st == ifgc_pkg::IFGC_IDLE && !start) begin
      r_next.gate_open_flag = 1'b0; // R15
    end

    // clear beats a same-cycle edge and leaves the gate alone
    if (clr) begin
      r_next.count = 16'h0000; // R06 R12
    end else if (count_ev) begin
      r_next.count = sat_inc(r_reg.count); // R04 R05
    end
  end

  // ************************************************************
  // register
  // ************************************************************

  // every field, selection bits included, comes up zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      r_reg <= '0; // R22
    end else begin
      r_reg <= r_next;
    end
  end

endmodule : ifgc_top
